/* hw/flash_lat_pkg.sv */
package flash_lat_pkg;

    // Clocking of the user side and of the host serial clock
    localparam int CLK_MHZ = 200;
    localparam int SCK_HALF = 4;
    localparam logic [2:0] DIV_LAST = 3'(SCK_HALF - 1);
    localparam logic [7:0] SCK_MHZ = 8'(CLK_MHZ / (2 * SCK_HALF));
    localparam logic [7:0] SDR_MAX_MHZ = 8'h85;
    localparam logic [7:0] DDR_MAX_MHZ = 8'h42;

    // Command opcodes
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_QIO_READ = 8'hEB;
    localparam logic [7:0] CMD_READ_ANY = 8'h65;
    localparam logic [7:0] CMD_SEC_READ = 8'h4B;
    localparam logic [7:0] CMD_PARAM_READ = 8'h5A;
    localparam logic [7:0] CMD_UID_READ = 8'h4C;
    localparam logic [7:0] CMD_DPD_EXIT = 8'hAB;

    // Edge counts of each frame phase
    localparam logic [5:0] NO_EDGES = 6'h00;
    localparam logic [5:0] CMD_EDGES_1 = 6'h08;
    localparam logic [5:0] CMD_EDGES_4 = 6'h02;
    localparam logic [5:0] ADDR_EDGES_1 = 6'h18;
    localparam logic [5:0] ADDR_EDGES_4 = 6'h06;
    localparam logic [5:0] MODE_EDGES_QIO = 6'h02;
    localparam logic [5:0] DUMMY_DEFAULT = 6'h08;
    localparam logic [5:0] DUMMY_UID = 6'h20;
    localparam logic [5:0] DUMMY_DPD = 6'h18;
    localparam logic [5:0] BYTE_EDGES_1 = 6'h08;
    localparam logic [5:0] BYTE_EDGES_4 = 6'h02;

    // Latency code field, bits 3 to 0
    localparam int LAT_W = 4;
    typedef logic [LAT_W-1:0] lat_t;

    // Frame phases, Gray along the usual path
    typedef enum logic [2:0] {
        PH_CMD = 3'b000,
        PH_ADDR = 3'b001,
        PH_MODE = 3'b011,
        PH_DUMMY = 3'b010,
        PH_DATA = 3'b110,
        PH_IGNORE = 3'b111
    } phase_t;

    // Command accepted in this command form
    function automatic logic known(input logic [7:0] c, input logic fl);
        case (c)
            CMD_READ: return !fl;
            CMD_QIO_READ, CMD_READ_ANY, CMD_SEC_READ: return 1'b1;
            CMD_PARAM_READ, CMD_UID_READ, CMD_DPD_EXIT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : known

    // Address, mode and data carried on four lines
    function automatic logic wide(input logic [7:0] c, input logic fl);
        return fl || (c == CMD_QIO_READ);
    endfunction : wide

    // Commands whose dummy count follows the latency code
    function automatic logic var_lat(input logic [7:0] c);
        return (c == CMD_QIO_READ) || (c == CMD_READ_ANY) ||
               (c == CMD_SEC_READ) || (c == CMD_PARAM_READ);
    endfunction : var_lat

    // Edge count of one phase for a command
    function automatic logic [5:0] phase_len(input phase_t ph, input logic [7:0] c,
                                             input logic fl, input lat_t lat);
        case (ph)
            PH_CMD: return fl ? CMD_EDGES_4 : CMD_EDGES_1;
            PH_ADDR: begin
                if ((c == CMD_UID_READ) || (c == CMD_DPD_EXIT)) return NO_EDGES;
                return wide(c, fl) ? ADDR_EDGES_4 : ADDR_EDGES_1;
            end
            // Mode cycles kept apart from dummies
            PH_MODE: return (c == CMD_QIO_READ) ? MODE_EDGES_QIO : NO_EDGES;
            PH_DUMMY: begin
                if (c == CMD_UID_READ) return DUMMY_UID;
                if (c == CMD_DPD_EXIT) return DUMMY_DPD;
                if (!var_lat(c)) return NO_EDGES;
                if (lat == '0) return DUMMY_DEFAULT;
                return {2'b00, lat};
            end
            default: return NO_EDGES;
        endcase
    endfunction : phase_len

    // Next non-empty phase after a finished one
    function automatic phase_t advance(input phase_t ph, input logic [7:0] c,
                                       input logic fl, input lat_t lat);
        if (ph == PH_CMD && phase_len(PH_ADDR, c, fl, lat) != NO_EDGES) return PH_ADDR;
        if ((ph == PH_CMD || ph == PH_ADDR) && phase_len(PH_MODE, c, fl, lat) != NO_EDGES)
            return PH_MODE;
        if (ph != PH_DUMMY && phase_len(PH_DUMMY, c, fl, lat) != NO_EDGES) return PH_DUMMY;
        return PH_DATA;
    endfunction : advance

endpackage : flash_lat_pkg

/* hw/flash_link_if.sv */
`timescale 1ns/1ps
interface flash_link_if;
    logic sck; // Serial clock from host
    logic cs_n; // Chip select, active low
    logic [3:0] host_io_o; // Host drive values
    logic [3:0] host_io_oe; // Host drive enables
    logic [3:0] dev_io_o; // Device drive values
    logic [3:0] dev_io_oe; // Device drive enables
    logic [3:0] io; // Resolved lines, pulled high when idle

    // Wire level from enables
    assign io = (host_io_oe & host_io_o) | (dev_io_oe & dev_io_o) | ~(host_io_oe | dev_io_oe);

    modport host (output sck, output cs_n, output host_io_o, output host_io_oe, input io);
    modport dev (input sck, input cs_n, input io, output dev_io_o, output dev_io_oe);
endinterface : flash_link_if

/* hw/flash_lat_dev.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Host picks code rated for its clock
// - Host clock at most 133 SDR, 66 DDR
// - Mode cycles excluded from dummy count
// - Quad I/O read carries two mode cycles
// - Faster quad reads need larger latency code
// - Plain read has zero dummies
// - Unique ID read has 32 dummies
// - Power-down release has 24 dummies
// - Latency code is 4-bit volatile field
// - Reset loads code from non-volatile bits
module flash_lat_dev (
    input wire logic clock_i, // User side clock
    input wire logic arst_n_i, // Async reset, active low
    flash_link_if.dev link, // Serial link, device end
    input wire flash_lat_pkg::lat_t nv_latency_i, // Non-volatile latency bits
    input wire logic soft_reset_i, // Software reset request
    input wire logic cfg_wr_i, // Write volatile config
    input wire flash_lat_pkg::lat_t cfg_latency_i, // New latency code
    input wire logic cfg_four_line_i, // New four-line command mode
    output logic cfg_busy_o, // Config update in flight
    output flash_lat_pkg::lat_t latency_o, // Volatile latency code
    output logic four_line_o // Four-line command mode
);
    import flash_lat_pkg::*;

    // User side config state
    typedef struct packed {
        logic pend; // Load from non-volatile bits owed
        lat_t lat; // Volatile latency field
        logic fl; // Four-line command mode
        logic req; // Handshake toggle to link
        logic ack_s1; // Ack synchroniser, first stage
        logic ack_s2; // Ack synchroniser, second stage
    } ucfg_t;

    // Link side copy of config
    typedef struct packed {
        logic req_s1; // Req synchroniser, first stage
        logic req_s2; // Req synchroniser, second stage
        logic seen; // Last request taken
        lat_t lat; // Latency code in use
        logic fl; // Four-line mode in use
    } lcfg_t;

    // Per-frame state, cleared while deselected
    typedef struct packed {
        phase_t phase; // Frame phase
        logic [5:0] cnt; // Edges within phase
        logic fl; // Mode frozen for frame
        lat_t lat; // Code frozen for frame
        logic [7:0] cmd; // Command byte
        logic [23:0] addr; // Address
        logic [7:0] idx; // Bytes sent
        logic [7:0] sh; // Output byte shifter
        logic [3:0] out; // Line drive values
        logic [3:0] oe; // Line drive enables
    } frame_t;

    ucfg_t u_r;
    ucfg_t u_nxt;
    lcfg_t lc_r;
    lcfg_t lc_nxt;
    frame_t f_r;
    frame_t f_nxt;
    logic busy; // Handshake outstanding
    logic frame_rst_n; // Frame reset, also on deselect

    assign busy = u_r.req != u_r.ack_s2;
    assign frame_rst_n = arst_n_i & ~link.cs_n;

    // User side: reset load, writes, handshake
    always_comb begin
        u_nxt = u_r;
        u_nxt.ack_s1 = lc_r.seen;
        u_nxt.ack_s2 = u_r.ack_s1;
        if (soft_reset_i) begin
            // Set wins over the clear below
            u_nxt.pend = 1'b1;
        end else if (!busy && u_r.pend) begin
            // Boot with the stored latency
            u_nxt.lat = nv_latency_i;
            u_nxt.fl = 1'b0;
            u_nxt.req = ~u_r.req;
            u_nxt.pend = 1'b0;
        end else if (!busy && cfg_wr_i) begin
            // Runtime change of the field
            u_nxt.lat = cfg_latency_i;
            u_nxt.fl = cfg_four_line_i;
            u_nxt.req = ~u_r.req;
        end
    end

    // User side registers, load owed from reset
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            u_r <= '0;
            u_r.pend <= 1'b1;
        end else begin
            u_r <= u_nxt;
        end
    end

    // Link side: take word when request toggles
    always_comb begin
        lc_nxt = lc_r;
        lc_nxt.req_s1 = u_r.req;
        lc_nxt.req_s2 = lc_r.req_s1;
        if (lc_r.req_s2 != lc_r.seen) begin
            // Word is held steady until ack returns
            lc_nxt.lat = u_r.lat;
            lc_nxt.fl = u_r.fl;
            lc_nxt.seen = lc_r.req_s2;
        end
    end

    // Link config registers
    always_ff @(posedge link.sck or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lc_r <= '0;
        end else begin
            lc_r <= lc_nxt;
        end
    end

    // Frame sequencer, sampled on rising SCK
    always_comb begin
        logic first;
        logic fl;
        lat_t lat;
        logic w;
        logic [7:0] b;
        first = 1'b0;
        fl = f_r.fl;
        lat = f_r.lat;
        w = 1'b0;
        b = 8'h00;
        f_nxt = f_r;
        // Freeze config at the first edge
        if (f_r.phase == PH_CMD && f_r.cnt == NO_EDGES) begin
            first = 1'b1;
        end
        if (first) begin
            fl = lc_r.fl;
            lat = lc_r.lat;
        end
        f_nxt.fl = fl;
        f_nxt.lat = lat;
        case (f_r.phase)
            PH_CMD: begin
                // Opcode on one or four lines
                f_nxt.cmd = fl ? {f_r.cmd[3:0], link.io} : {f_r.cmd[6:0], link.io[0]};
                f_nxt.cnt = f_r.cnt + 6'h01;
                if (f_nxt.cnt == phase_len(PH_CMD, f_nxt.cmd, fl, lat)) begin
                    f_nxt.cnt = NO_EDGES;
                    if (known(f_nxt.cmd, fl)) begin
                        f_nxt.phase = advance(PH_CMD, f_nxt.cmd, fl, lat);
                    end else begin
                        // Unknown opcode, stay quiet to deselect
                        f_nxt.phase = PH_IGNORE;
                    end
                end
            end
            PH_ADDR: begin
                // Address on one or four lines
                w = wide(f_r.cmd, fl);
                f_nxt.addr = w ? {f_r.addr[19:0], link.io} : {f_r.addr[22:0], link.io[0]};
                f_nxt.cnt = f_r.cnt + 6'h01;
                if (f_nxt.cnt == phase_len(PH_ADDR, f_r.cmd, fl, lat)) begin
                    f_nxt.cnt = NO_EDGES;
                    f_nxt.phase = advance(PH_ADDR, f_r.cmd, fl, lat);
                end
            end
            PH_MODE: begin
                // Mode bits counted on their own
                f_nxt.cnt = f_r.cnt + 6'h01;
                if (f_nxt.cnt == phase_len(PH_MODE, f_r.cmd, fl, lat)) begin
                    f_nxt.cnt = NO_EDGES;
                    f_nxt.phase = advance(PH_MODE, f_r.cmd, fl, lat);
                end
            end
            PH_DUMMY: begin
                // Dummy edges from the latency code, or the fixed counts of unique ID read and power-down release
                f_nxt.cnt = f_r.cnt + 6'h01;
                if (f_nxt.cnt == phase_len(PH_DUMMY, f_r.cmd, fl, lat)) begin
                    f_nxt.cnt = NO_EDGES;
                    f_nxt.phase = PH_DATA;
                end
            end
            default: begin
                // Data and ignore hold their phase
                f_nxt.phase = f_r.phase;
            end
        endcase
        // Output data launched from the entry edge on
        if (f_nxt.phase == PH_DATA) begin
            w = wide(f_nxt.cmd, fl);
            if (f_r.phase != PH_DATA || f_r.cnt == NO_EDGES) begin
                b = f_nxt.addr[7:0] + f_r.idx;
                f_nxt.idx = f_r.idx + 8'h01;
                f_nxt.cnt = (w ? BYTE_EDGES_4 : BYTE_EDGES_1) - 6'h01;
            end else begin
                b = f_r.sh;
                f_nxt.cnt = f_r.cnt - 6'h01;
            end
            f_nxt.out = w ? b[7:4] : {2'b00, b[7], 1'b0};
            f_nxt.sh = w ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
            f_nxt.oe = w ? 4'hF : 4'h2;
        end
    end

    // Frame registers, cleared by deselect
    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end

    // Outputs
    assign link.dev_io_o = f_r.out;
    assign link.dev_io_oe = f_r.oe;
    assign cfg_busy_o = busy | u_r.pend;
    assign latency_o = u_r.lat;
    assign four_line_o = u_r.fl;

endmodule : flash_lat_dev

/* hw/flash_lat_host.sv */
`timescale 1ns/1ps
module flash_lat_host (
    input wire logic clock_i, // Host clock
    input wire logic arst_n_i, // Async reset, active low
    flash_link_if.host link, // Serial link, host end
    input wire logic start_i, // Start a read frame
    input wire logic [7:0] cmd_i, // Command opcode
    input wire logic [23:0] addr_i, // Address
    input wire logic [7:0] mode_bits_i, // Mode byte for quad read
    input wire logic four_line_i, // Four-line command form
    input wire flash_lat_pkg::lat_t latency_i, // Code set in the device
    input wire logic [7:0] nbytes_i, // Bytes to read, nonzero
    output logic busy_o, // Frame in progress
    output logic [7:0] rd_data_o, // Received byte
    output logic rd_valid_o, // Byte strobe
    output logic done_o, // Frame finished strobe
    output logic err_o // Start refused strobe
);
    import flash_lat_pkg::*;

    // Frequency limit per code, MHz; code 0 rated as code 8
    localparam logic [7:0] LIM_1 [16] = '{8'h6C, 8'h32, 8'h41, 8'h4B, 8'h55, 8'h5F,
        8'h6C, 8'h6C, 8'h6C, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85};
    localparam logic [7:0] LIM_4 [16] = '{8'h55, 8'h0F, 8'h19, 8'h23, 8'h2D, 8'h37,
        8'h41, 8'h4B, 8'h55, 8'h5F, 8'h6C, 8'h73, 8'h73, 8'h78, 8'h78, 8'h85};

    typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_RUN = 2'b01, HS_END = 2'b11} hst_t;

    // All host state
    typedef struct packed {
        hst_t st; // Frame state
        phase_t phase; // Frame phase
        logic [2:0] div; // SCK half-period divider
        logic sck; // Serial clock
        logic cs_n; // Chip select
        logic [5:0] cnt; // Edges within phase
        logic [39:0] tx; // Opcode, address, mode
        logic fl; // Four-line form
        lat_t lat; // Latency code
        logic [7:0] cmd; // Opcode
        logic [7:0] left; // Bytes still owed
        logic [7:0] rx; // Input shifter
        logic [3:0] out; // Drive values
        logic [3:0] oe; // Drive enables
        logic [3:0] io_s1; // Line sync, first stage
        logic [3:0] io_s2; // Line sync, second stage
        logic [7:0] rd_data; // Received byte
        logic rd_valid; // Byte strobe
        logic done; // Done strobe
        logic err; // Refusal strobe
    } host_t;

    host_t h_r;
    host_t h_nxt;

    // Next host state
    always_comb begin
        logic w;
        logic rise;
        logic slow;
        logic [39:0] t;
        w = 1'b0;
        rise = 1'b0;
        t = {cmd_i, addr_i, mode_bits_i};
        h_nxt = h_r;
        h_nxt.io_s1 = link.io;
        h_nxt.io_s2 = h_r.io_s1;
        h_nxt.rd_valid = 1'b0;
        h_nxt.done = 1'b0;
        h_nxt.err = 1'b0;
        // Code must be rated at or above our SCK
        slow = var_lat(cmd_i) && ((four_line_i ? LIM_4[latency_i] : LIM_1[latency_i]) < SCK_MHZ);
        case (h_r.st)
            HS_IDLE: begin
                if (start_i) begin
                    // SCK never above the SDR ceiling
                    if (!known(cmd_i, four_line_i) || nbytes_i == 8'h00 || slow ||
                        SCK_MHZ > SDR_MAX_MHZ) begin
                        h_nxt.err = 1'b1;
                    end else begin
                        h_nxt.st = HS_RUN;
                        h_nxt.cs_n = 1'b0;
                        h_nxt.phase = PH_CMD;
                        h_nxt.cnt = NO_EDGES;
                        h_nxt.div = 3'h0;
                        h_nxt.tx = t;
                        h_nxt.fl = four_line_i;
                        h_nxt.lat = latency_i;
                        h_nxt.cmd = cmd_i;
                        h_nxt.left = nbytes_i;
                        h_nxt.out = four_line_i ? t[39:36] : {3'b000, t[39]};
                        h_nxt.oe = four_line_i ? 4'hF : 4'h1;
                    end
                end
            end
            HS_RUN: begin
                w = (h_r.phase == PH_CMD) ? h_r.fl : wide(h_r.cmd, h_r.fl);
                if (h_r.div == DIV_LAST) begin
                    h_nxt.div = 3'h0;
                    h_nxt.sck = ~h_r.sck;
                    rise = ~h_r.sck;
                end else begin
                    h_nxt.div = h_r.div + 3'h1;
                end
                if (rise && h_r.phase == PH_DATA) begin
                    // Sample the device lines
                    h_nxt.rx = w ? {h_r.rx[3:0], h_r.io_s2} : {h_r.rx[6:0], h_r.io_s2[1]};
                    if (h_r.cnt == (w ? BYTE_EDGES_4 : BYTE_EDGES_1) - 6'h01) begin
                        h_nxt.cnt = NO_EDGES;
                        h_nxt.rd_data = h_nxt.rx;
                        h_nxt.rd_valid = 1'b1;
                        h_nxt.left = h_r.left - 8'h01;
                        if (h_r.left == 8'h01) begin
                            h_nxt.st = HS_END;
                        end
                    end else begin
                        h_nxt.cnt = h_r.cnt + 6'h01;
                    end
                end else if (rise) begin
                    // Device took our bits; count the phase
                    h_nxt.tx = w ? {h_r.tx[35:0], 4'h0} : {h_r.tx[38:0], 1'b0};
                    h_nxt.cnt = h_r.cnt + 6'h01;
                    if (h_nxt.cnt == phase_len(h_r.phase, h_r.cmd, h_r.fl, h_r.lat)) begin
                        h_nxt.cnt = NO_EDGES;
                        h_nxt.phase = advance(h_r.phase, h_r.cmd, h_r.fl, h_r.lat);
                    end
                end else if (h_r.div == DIV_LAST) begin
                    // Falling edge: set up the next bits
                    if (h_r.phase == PH_DUMMY || h_r.phase == PH_DATA) begin
                        h_nxt.oe = 4'h0;
                        h_nxt.out = 4'h0;
                    end else begin
                        h_nxt.out = w ? h_r.tx[39:36] : {3'b000, h_r.tx[39]};
                        h_nxt.oe = w ? 4'hF : 4'h1;
                    end
                end
            end
            HS_END: begin
                // Bring SCK low, then deselect
                if (h_r.div == DIV_LAST) begin
                    h_nxt.div = 3'h0;
                    if (h_r.sck) begin
                        h_nxt.sck = 1'b0;
                    end else begin
                        h_nxt.cs_n = 1'b1;
                        h_nxt.done = 1'b1;
                        h_nxt.st = HS_IDLE;
                    end
                end else begin
                    h_nxt.div = h_r.div + 3'h1;
                end
            end
            default: begin
                h_nxt.st = HS_IDLE;
            end
        endcase
    end

    // Host registers
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            h_r <= '0;
            h_r.cs_n <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    // Outputs
    assign link.sck = h_r.sck;
    assign link.cs_n = h_r.cs_n;
    assign link.host_io_o = h_r.out;
    assign link.host_io_oe = h_r.oe;
    assign busy_o = h_r.st != HS_IDLE;
    assign rd_data_o = h_r.rd_data;
    assign rd_valid_o = h_r.rd_valid;
    assign done_o = h_r.done;
    assign err_o = h_r.err;

endmodule : flash_lat_host

/* test/flash_read_latency_timing_asserts.sv */
`timescale 1ns/1ps
module flash_read_latency_timing_asserts (
    input wire logic clock_i, // User side clock
    input wire logic arst_n_i, // Reset, active low
    input wire logic sck, // Serial clock
    input wire logic cs_n, // Select, active low
    input wire logic [3:0] host_io_o, // Host values
    input wire logic [3:0] host_io_oe, // Host enables
    input wire logic [3:0] dev_io_o, // Device values
    input wire logic [3:0] dev_io_oe // Device enables
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // Framing and clock shape on the user clock
    chk_sck_idle_low: assert property (cs_n |-> !sck) else $error("sck high while deselected");
    chk_dev_quiet_idle: assert property (cs_n && $past(cs_n) |-> dev_io_oe == 4'h0)
        else $error("device drives while deselected");
    chk_host_oe_framed: assert property (host_io_oe != 4'h0 |-> !cs_n)
        else $error("host drives while deselected");
    chk_select_setup: assert property ($fell(cs_n) |-> !sck [*3])
        else $error("sck rose too soon after select");
    chk_sck_high_half: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("sck high half not four cycles");
    chk_sck_low_half: assert property ($fell(sck) && !cs_n |-> !sck [*4])
        else $error("sck low half too short");
    // Host bits hold while sck is high
    chk_host_hold_high: assert property (sck && $past(sck) |-> $stable(host_io_o))
        else $error("host lines moved while sck high");
    // Device launches only from a rising serial edge
    chk_dev_launch_rise: assert property (!cs_n && ($changed(dev_io_o) || $changed(dev_io_oe)) |-> $rose(sck))
        else $error("device output moved off a rising edge");
    cov_frame: cover property ($fell(cs_n));
    cov_dev_drive: cover property ($rose(dev_io_oe != 4'h0));
    cov_four_line: cover property (host_io_oe == 4'hF);
endmodule : flash_read_latency_timing_asserts

/* test/flash_read_latency_timing_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module flash_read_latency_timing_bench;
    import flash_lat_pkg::*;
    logic clock_i = 1'b0; // Bench clock
    logic arst_n_i = 1'b0; // Reset, active low
    logic start_i = 1'b0, four_line_i = 1'b0, soft_reset_i = 1'b0, cfg_wr_i = 1'b0, cfg_four_line_i = 1'b0;
    logic [7:0] cmd_i = 8'h00, mode_bits_i = 8'h00, nbytes_i = 8'h02, rd_data_o;
    logic [23:0] addr_i = 24'h000000; // Frame address
    lat_t latency_i = 4'h0, nv_latency_i = 4'h5, cfg_latency_i = 4'h0, latency_o, cur_lat = 4'h0;
    logic busy_o, rd_valid_o, done_o, err_o, cfg_busy_o, four_line_o, sck_q = 1'b0, seen = 1'b0, cur_fl = 1'b0;
    int n_fail = 0, n_checks = 0, edges = 0, first = 0, cnt_n, cycles = 0;
    logic [7:0] got[$]; // Received bytes of a frame
    flash_link_if flash_link_if_inst ();
    flash_lat_dev flash_lat_dev_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(flash_link_if_inst),
        .nv_latency_i(nv_latency_i), .soft_reset_i(soft_reset_i), .cfg_wr_i(cfg_wr_i),
        .cfg_latency_i(cfg_latency_i), .cfg_four_line_i(cfg_four_line_i), .cfg_busy_o(cfg_busy_o),
        .latency_o(latency_o), .four_line_o(four_line_o));
    flash_lat_host flash_lat_host_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(flash_link_if_inst),
        .start_i(start_i), .cmd_i(cmd_i), .addr_i(addr_i), .mode_bits_i(mode_bits_i), .four_line_i(four_line_i),
        .latency_i(latency_i), .nbytes_i(nbytes_i), .busy_o(busy_o), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .done_o(done_o), .err_o(err_o));
    flash_read_latency_timing_asserts flash_read_latency_timing_asserts_inst (.clock_i(clock_i),
        .arst_n_i(arst_n_i), .sck(flash_link_if_inst.sck), .cs_n(flash_link_if_inst.cs_n),
        .host_io_o(flash_link_if_inst.host_io_o), .host_io_oe(flash_link_if_inst.host_io_oe),
        .dev_io_o(flash_link_if_inst.dev_io_o), .dev_io_oe(flash_link_if_inst.dev_io_oe));
    initial forever #2.5 clock_i = ~clock_i;
    // Count sck rises per frame, note first device drive
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        sck_q <= flash_link_if_inst.sck;
        cnt_n = edges + ((flash_link_if_inst.sck && !sck_q) ? 1 : 0);
        if (flash_link_if_inst.cs_n) begin
            edges <= 0;
            seen <= 1'b0;
        end else begin
            edges <= cnt_n;
            if (flash_link_if_inst.dev_io_oe != 4'h0 && !seen) begin
                seen <= 1'b1;
                first <= cnt_n;
            end
        end
        if (rd_valid_o) got.push_back(rd_data_o);
        if (cycles == 60000) begin
            n_fail++;
            final_report();
        end
    end
    // One read; k is the expected launch edge, -1 a refused start, -2 only the done check
    task automatic frame(input logic [7:0] c, input logic fl, input lat_t lat, input int k);
        int w;
        logic [7:0] base;
        base = (c == CMD_UID_READ || c == CMD_DPD_EXIT) ? 8'h00 : 8'h3C;
        @(posedge clock_i);
        cmd_i <= c;
        four_line_i <= fl;
        latency_i <= lat;
        addr_i <= 24'h12343C;
        first <= 0;
        got.delete();
        start_i <= 1'b1;
        @(posedge clock_i);
        start_i <= 1'b0;
        @(negedge clock_i);
        if (k == -1) begin
            `CHK(err_o, 1'b1)
            `CHK(busy_o, 1'b0)
        end else begin
            w = 0;
            while (done_o !== 1'b1 && w < 3000) begin @(negedge clock_i); w++; end
            `CHK(done_o, 1'b1)
            if (k >= 0) begin
                `CHK(first, k)
                `CHK(got.size(), 2)
                `CHK(got[0], base)
                `CHK(got[1], base + 8'h01)
            end
        end
    endtask : frame
    // Hand the code to the link side by one frame
    task automatic sync(input lat_t lat, input logic fl);
        int w;
        frame(CMD_READ_ANY, cur_fl, cur_lat, -2);
        w = 0;
        while (cfg_busy_o !== 1'b0 && w < 2000) begin @(negedge clock_i); w++; end
        `CHK(cfg_busy_o, 1'b0)
        cur_lat = lat;
        cur_fl = fl;
    endtask : sync
    task automatic set_cfg(input lat_t lat, input logic fl);
        @(posedge clock_i);
        cfg_wr_i <= 1'b1;
        cfg_latency_i <= lat;
        cfg_four_line_i <= fl;
        @(posedge clock_i);
        cfg_wr_i <= 1'b0;
        @(negedge clock_i);
        `CHK(latency_o, lat)
        `CHK(four_line_o, fl)
        sync(lat, fl);
    endtask : set_cfg
    task automatic t_fixed();
        frame(CMD_READ, 1'b0, cur_lat, 32);
        frame(CMD_UID_READ, 1'b0, cur_lat, 40);
        frame(CMD_DPD_EXIT, 1'b0, cur_lat, 32);
        $display("test fixed latency done");
    endtask : t_fixed
    task automatic t_code0();
        set_cfg(4'h0, 1'b0);
        frame(CMD_READ_ANY, 1'b0, 4'h0, 40);
        frame(CMD_SEC_READ, 1'b0, 4'h0, 40);
        frame(CMD_PARAM_READ, 1'b0, 4'h0, 40);
        frame(CMD_QIO_READ, 1'b0, 4'h0, 24);
        set_cfg(4'hF, 1'b0);
        frame(CMD_QIO_READ, 1'b0, 4'hF, 31);
        frame(CMD_SEC_READ, 1'b0, 4'hF, 47);
        $display("test latency codes done");
    endtask : t_code0
    task automatic t_soft();
        @(posedge clock_i);
        soft_reset_i <= 1'b1;
        nv_latency_i <= 4'h9;
        @(posedge clock_i);
        soft_reset_i <= 1'b0;
        repeat (4) @(negedge clock_i);
        `CHK(latency_o, 4'h9)
        `CHK(four_line_o, 1'b0)
        sync(4'h9, 1'b0);
        frame(CMD_READ_ANY, 1'b0, 4'h9, 41);
        $display("test soft reset done");
    endtask : t_soft
    task automatic t_four();
        set_cfg(4'h2, 1'b1);
        frame(CMD_READ_ANY, 1'b1, 4'h2, 10);
        frame(CMD_QIO_READ, 1'b1, 4'h2, 12);
        set_cfg(4'h1, 1'b1);
        frame(CMD_READ_ANY, 1'b1, 4'h1, -1);
        $display("test four line done");
    endtask : t_four
    task automatic t_boot();
        `CHK(latency_o, 4'h5)
        sync(4'h5, 1'b0);
        frame(CMD_READ_ANY, 1'b0, 4'h5, 37);
        $display("test boot done");
    endtask : t_boot
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        repeat (5) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (2) @(negedge clock_i);
        t_boot();
        t_fixed();
        t_code0();
        t_soft();
        t_four();
        final_report();
    end
endmodule : flash_read_latency_timing_bench
